// ===== pkg/comparator_control_pkg.sv
// shared constants for the comparator control block
package comparator_control_pkg;
	// register byte addresses (one aligned word each)
	localparam logic [11:0] ctrl_addr = 12'h000; // comparator_control
	localparam logic [11:0] flag_addr = 12'h004; // interrupt flag / enable
	localparam logic [11:0] core_addr = 12'h008; // core power state
	// comparator_control field positions
	localparam int hysteresis_on_pos = 0;
	localparam int compare_result_pos = 4;
	localparam int output_invert_pos = 5;
	localparam int comparator_on_pos = 6;
	// flag register field positions
	localparam int irq_flag_pos = 0;
	localparam int irq_enable_pos = 1;
	// core power register field positions
	localparam int sleep_pos = 0;
	localparam int idle_pos = 1;
	// values after reset
	localparam logic hysteresis_on_rst = 1'h1;
	localparam logic output_invert_rst = 1'h0;
	localparam logic comparator_on_rst = 1'h0;
	localparam logic irq_flag_rst = 1'h0;
	localparam logic irq_enable_rst = 1'h0;
	// power state of the core
	typedef enum logic [1:0] {
		comparator_control_run_t_run = 2'h0,
		comparator_control_run_t_idle = 2'h1,
		comparator_control_run_t_sleep = 2'h3
	} comparator_control_pwr_t;
endpackage

// ===== rtl/comparator_control_ctrl.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - enable clear powers off, forces result low
// - polarity bit inverts raw result
// - result one when plus exceeds minus
// - hysteresis bit zero, resets to one
// - unimplemented bits read as zero
// - result change sets flag, requests vector
// - change in sleep or idle wakes core unless flag already set
// - enabled comparator stays on in low power
module comparator_control_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic raw_compare,
	output logic comparator_on,
	output logic hysteresis_on,
	output logic compare_result,
	output logic irq_request,
	output logic wake_request
);

////////////////////////////////////////////////////////////////////////
// register state

logic output_invert; // polarity select
logic irq_flag; // sticky change flag
logic irq_enable; // vector jump enable
comparator_control_pkg::comparator_control_pwr_t pwr; // core power state
logic sync_a; // first synchroniser stage
logic sync_b; // second synchroniser stage
logic next_result; // polarity-applied result
logic result_change; // one-cycle change event
logic wr_en; // apb write strobe
logic rd_ok; // mapped address

// address decode used by read and write paths
function automatic logic is_mapped(input logic [11:0] a);
	is_mapped = (a == comparator_control_pkg::ctrl_addr) ||
		(a == comparator_control_pkg::flag_addr) || (a == comparator_control_pkg::core_addr);
endfunction

// zero-wait slave; unmapped addresses answer with pslverr
assign pready = 1'b1;
assign rd_ok = is_mapped(paddr);
assign pslverr = psel && penable && !rd_ok;
assign wr_en = psel && penable && pwrite && rd_ok;

////////////////////////////////////////////////////////////////////////
// raw result crossing; analog output is asynchronous to pclk

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync_a <= 1'b0;
		sync_b <= 1'b0;
	end else begin
		sync_a <= raw_compare;
		sync_b <= sync_a;
	end
end

// polarity and enable gating; off forces result low
always_comb begin
	if (!comparator_on) begin
		next_result = 1'b0;
	end else begin
		next_result = sync_b ^ output_invert;
	end
end

// registered result bit
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		compare_result <= 1'b0;
	end else begin
		compare_result <= next_result;
	end
end

// any change of the result bit, including from enable or polarity
assign result_change = next_result != compare_result;

////////////////////////////////////////////////////////////////////////
// control register writes

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		comparator_on <= comparator_control_pkg::comparator_on_rst;
		output_invert <= comparator_control_pkg::output_invert_rst;
		hysteresis_on <= comparator_control_pkg::hysteresis_on_rst;
	end else if (wr_en && paddr == comparator_control_pkg::ctrl_addr) begin
		// no power-state gating: stays on in sleep/idle
		comparator_on <= pwdata[comparator_control_pkg::comparator_on_pos];
		output_invert <= pwdata[comparator_control_pkg::output_invert_pos];
		hysteresis_on <= pwdata[comparator_control_pkg::hysteresis_on_pos];
	end
end

// interrupt enable
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_enable <= comparator_control_pkg::irq_enable_rst;
	end else if (wr_en && paddr == comparator_control_pkg::flag_addr) begin
		irq_enable <= pwdata[comparator_control_pkg::irq_enable_pos];
	end
end

// sticky flag; hardware set beats a software clear in the same cycle
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_flag <= comparator_control_pkg::irq_flag_rst;
	end else if (result_change) begin
		irq_flag <= 1'b1;
	end else if (wr_en && paddr == comparator_control_pkg::flag_addr) begin
		// software may preset the flag high to mask wakeups
		irq_flag <= pwdata[comparator_control_pkg::irq_flag_pos];
	end
end

////////////////////////////////////////////////////////////////////////
// core power state as told by software

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pwr <= comparator_control_pkg::comparator_control_run_t_run;
	end else if (wake_request) begin
		pwr <= comparator_control_pkg::comparator_control_run_t_run;
	end else if (wr_en && paddr == comparator_control_pkg::core_addr) begin
		case ({pwdata[comparator_control_pkg::idle_pos], pwdata[comparator_control_pkg::sleep_pos]})
		2'b01, 2'b11: begin
			pwr <= comparator_control_pkg::comparator_control_run_t_sleep;
		end
		2'b10: begin
			pwr <= comparator_control_pkg::comparator_control_run_t_idle;
		end
		default: begin
			pwr <= comparator_control_pkg::comparator_control_run_t_run;
		end
		endcase
	end
end

// vector request follows the flag while enabled
assign irq_request = irq_flag && irq_enable;

// wake only on a fresh rise of the flag; a preset flag gives none
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wake_request <= 1'b0;
	end else begin
		wake_request <= (pwr != comparator_control_pkg::comparator_control_run_t_run) &&
			comparator_on && result_change && !irq_flag;
	end
end

////////////////////////////////////////////////////////////////////////
// read data; registered, reserved bits zero

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
	end else begin
		prdata <= 32'h00000000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
			comparator_control_pkg::ctrl_addr: begin
				prdata[comparator_control_pkg::comparator_on_pos] <= comparator_on;
				prdata[comparator_control_pkg::output_invert_pos] <= output_invert;
				prdata[comparator_control_pkg::compare_result_pos] <= next_result;
				prdata[comparator_control_pkg::hysteresis_on_pos] <= hysteresis_on;
			end
			comparator_control_pkg::flag_addr: begin
				prdata[comparator_control_pkg::irq_flag_pos] <= irq_flag;
				prdata[comparator_control_pkg::irq_enable_pos] <= irq_enable;
			end
			comparator_control_pkg::core_addr: begin
				prdata[comparator_control_pkg::sleep_pos] <=
					pwr == comparator_control_pkg::comparator_control_run_t_sleep;
				prdata[comparator_control_pkg::idle_pos] <=
					pwr == comparator_control_pkg::comparator_control_run_t_idle;
			end
			default: begin
				prdata <= 32'h00000000;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////
// checks

sequence s_change;
	result_change && !irq_flag;
endsequence

a_off_forces_low: assert property (@(posedge pclk) disable iff (!presetn)
	!comparator_on |=> !compare_result)
	else $error("result not low while off");

a_polarity_applied: assert property (@(posedge pclk)
	disable iff (!presetn)
	comparator_on && $stable(comparator_on) && $stable(output_invert) &&
	$stable(sync_b) |=>
	compare_result == ($past(sync_b) ^ $past(output_invert)))
	else $error("polarity not applied");

a_change_sets_flag: assert property (@(posedge pclk)
	disable iff (!presetn)
	$changed(compare_result) |-> irq_flag)
	else $error("flag not set on change");

a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
	irq_flag && irq_enable |-> irq_request)
	else $error("irq request missing");

a_wake_on_change: assert property (@(posedge pclk)
	disable iff (!presetn)
	s_change ##0 (pwr != comparator_control_pkg::comparator_control_run_t_run) ##0 comparator_on
	|=> wake_request)
	else $error("no wake on change");

a_no_wake_preset: assert property (@(posedge pclk)
	disable iff (!presetn)
	irq_flag && $past(irq_flag) |-> !wake_request)
	else $error("wake with preset flag");

a_sync_two_stage: assert property (@(posedge pclk)
	disable iff (!presetn)
	comparator_on [*3] ##0 $stable(output_invert) |->
	next_result == ($past(raw_compare, 2) ^ output_invert))
	else $error("sync depth wrong");

a_hyst_reset: assert property (@(posedge pclk)
	$rose(presetn) |-> hysteresis_on)
	else $error("hysteresis reset wrong");

////////////////////////////////////////////////////////////////////////
// read-path, write, flag and low-power checks

// setup phase of a control-register read
sequence s_ctrl_read;
	psel && !penable && !pwrite && paddr == comparator_control_pkg::ctrl_addr;
endsequence

// reserved positions stay zero in what software sees
a_reserved_zero: assert property (@(posedge pclk)
	disable iff (!presetn)
	s_ctrl_read |=> prdata[3:1] == 3'h0 &&
	prdata[31:7] == 25'h0000000)
	else $error("reserved bits not zero");

// result bit read back is the gated, polarised result
a_result_read: assert property (@(posedge pclk)
	disable iff (!presetn)
	s_ctrl_read |=> prdata[comparator_control_pkg::compare_result_pos] ==
	$past(next_result))
	else $error("result bit read wrong");

// enable and hysteresis bits read back as held
a_enable_read: assert property (@(posedge pclk)
	disable iff (!presetn)
	s_ctrl_read |=>
	prdata[comparator_control_pkg::comparator_on_pos] == $past(comparator_on) &&
	prdata[comparator_control_pkg::hysteresis_on_pos] == $past(hysteresis_on))
	else $error("enable bits read wrong");

// hysteresis bit takes the written value
a_hyst_write: assert property (@(posedge pclk)
	disable iff (!presetn)
	wr_en && paddr == comparator_control_pkg::ctrl_addr |=>
	hysteresis_on == $past(pwdata[comparator_control_pkg::hysteresis_on_pos]))
	else $error("hysteresis write lost");

// wake is a single pulse and puts the core back in run
a_wake_one_cycle: assert property (@(posedge pclk)
	disable iff (!presetn)
	wake_request |=> !wake_request &&
	pwr == comparator_control_pkg::comparator_control_run_t_run)
	else $error("wake pulse too long");

// a running core never gets a wake pulse
a_no_wake_run: assert property (@(posedge pclk)
	disable iff (!presetn)
	pwr == comparator_control_pkg::comparator_control_run_t_run |=> !wake_request)
	else $error("wake while running");

// low-power modes never switch the comparator off by themselves
a_on_in_low_power: assert property (@(posedge pclk)
	disable iff (!presetn)
	comparator_on && pwr != comparator_control_pkg::comparator_control_run_t_run &&
	!(wr_en && paddr == comparator_control_pkg::ctrl_addr) |=> comparator_on)
	else $error("comparator dropped in low power");

// a change sets the flag even against a software clear
a_set_beats_clear: assert property (@(posedge pclk)
	disable iff (!presetn)
	result_change |=> irq_flag)
	else $error("flag lost on change");

endmodule

// ===== testbench/comparator_control_ctrl_tb_top.sv
`timescale 1ns/1ps
module comparator_control_ctrl_tb_top;
	// bench clock, apb drive and observed outputs
	logic pclk, presetn, psel, penable, pwrite, raw_compare;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, c_on, hyst, res, irq, wake, err;
	int num_errors, checks, n;
	// one row: control write, raw input, expected control read
	typedef struct packed {
		logic [7:0] wr;
		logic raw;
		logic [7:0] exp;
	} comparator_control_row_t;
	comparator_control_row_t rows [6];
	comparator_control_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .raw_compare(raw_compare),
		.comparator_on(c_on), .hysteresis_on(hyst),
		.compare_result(res), .irq_request(irq), .wake_request(wake));
	////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data taken while the access phase stands
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		// answer and read data taken at the rising edge with pready high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) num_errors++;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// count wake pulses over a short window
	task wakes(input int exp);
		int k;
		k = 0;
		repeat (8) begin
			@(negedge pclk);
			if (wake === 1'b1) k++;
		end
		chk(k, exp);
	endtask
	task finish_test;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// watchdog at 5000 cycles, well beyond the roughly 130 cycles the tests need
	initial begin
		#(25 * 5000);
		num_errors++;
		finish_test();
	end
	initial begin
		rows = '{'{8'h40, 1, 8'h50}, '{8'h60, 1, 8'h60},
			'{8'h60, 0, 8'h70}, '{8'h20, 0, 8'h20},
			'{8'hFF, 1, 8'h61}, '{8'h00, 0, 8'h00}};
		presetn = 0;
		{psel, penable, pwrite, raw_compare} = 0;
		paddr = 0;
		pwdata = 0;
		num_errors = 0;
		checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		// reset values
		chk(hyst, 1);
		apb(0, comparator_control_pkg::ctrl_addr, 0);
		chk(rd, 32'h01);
		$display("reset test done");
		// table: enable, polarity, reserved bits
		for (int i = 0; i < 6; i++) begin
			raw_compare <= rows[i].raw;
			apb(1, comparator_control_pkg::ctrl_addr, {24'h0, rows[i].wr});
			repeat (4) @(posedge pclk);
			apb(0, comparator_control_pkg::ctrl_addr, 0);
			chk(rd, {24'h0, rows[i].exp});
			chk(res, rows[i].exp[4]);
			chk(c_on, rows[i].exp[6]);
		end
		$display("table test done");
		// change sets flag and raises request
		apb(1, comparator_control_pkg::ctrl_addr, 32'h40);
		repeat (4) @(posedge pclk);
		apb(1, comparator_control_pkg::flag_addr, 32'h02);
		raw_compare <= 1;
		repeat (4) @(posedge pclk);
		apb(0, comparator_control_pkg::flag_addr, 0);
		chk(rd, 32'h03);
		chk(irq, 1);
		$display("flag test done");
		// change during sleep wakes exactly once
		apb(1, comparator_control_pkg::flag_addr, 32'h02);
		apb(1, comparator_control_pkg::core_addr, 32'h01);
		chk(c_on, 1);
		raw_compare <= 0;
		wakes(1);
		apb(0, comparator_control_pkg::core_addr, 0);
		chk(rd, 32'h00);
		// preset flag suppresses wake in idle
		apb(1, comparator_control_pkg::flag_addr, 32'h03);
		apb(1, comparator_control_pkg::core_addr, 32'h02);
		raw_compare <= 1;
		wakes(0);
		apb(0, comparator_control_pkg::core_addr, 0);
		chk(rd, 32'h02);
		$display("wake test done");
		// unmapped address is refused
		apb(0, 12'h00C, 0);
		chk(err, 1);
		chk(rd, 0);
		$display("unmapped test done");
		// reset in mid-run returns control to its reset values
		apb(1, comparator_control_pkg::ctrl_addr, 32'h60);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		chk(c_on, 0);
		chk(hyst, 1);
		chk(res, 0);
		presetn <= 1;
		@(posedge pclk);
		apb(0, comparator_control_pkg::ctrl_addr, 0);
		chk(rd, 32'h01);
		$display("mid reset test done");
		finish_test();
	end
endmodule
